// *** core/flash_table_pkg.sv ***
// Constants, field positions and types for the flash table access block
// Operation
// RULE1: Table read returns one byte at pointer
// RULE2: Program writes commit whole 64-byte blocks
// RULE3: Program erase clears one aligned 64-byte block
// RULE4: No software path to bulk erase
// RULE5: Stall instruction fetch while programming
// RULE6: Internal timer ends write or erase
// RULE7: Undecodable fetched word executes as no-op
// RULE8: All byte transfers pass one 8-bit latch
// RULE9: Table read loads latch from array
// RULE10: Table write fills holding register only
// RULE11: Table accesses are byte granular
// RULE12: Unlock port stores nothing, reads zero
// RULE13: Space select picks EEPROM or program flash
// RULE14: Configuration select overrides space select
// RULE15: Erase select turns start into erase
// RULE16: Permit bit needed, cleared at reset
// RULE17: Error flag set at start, cleared on completion
// RULE18: Start bit only settable, hardware clears it
// RULE19: Done flag sets on completion, software clears
// RULE20: Start ignored without permit or unlock
// RULE21: Pointer low bits pick holding byte
package flash_table_pkg;

  localparam int          PADDR_W         = 8;
  localparam int          PTR_W           = 22;
  localparam int          BLOCK_BYTES     = 64;
  localparam int          BLOCK_IDX_W     = 6;

  // Register byte offsets
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_UNLOCK      = 8'h04;
  localparam logic [7:0]  REG_LATCH       = 8'h08;
  localparam logic [7:0]  REG_POINTER     = 8'h0c;
  localparam logic [7:0]  REG_TABLE_OP    = 8'h10;
  localparam logic [7:0]  REG_STATUS      = 8'h14;

  // Control register fields
  localparam int          CTRL_SPACE_BIT  = 7;
  localparam int          CTRL_CFG_BIT    = 6;
  localparam int          CTRL_ERASE_BIT  = 4;
  localparam int          CTRL_ERR_BIT    = 3;
  localparam int          CTRL_PERMIT_BIT = 2;
  localparam int          CTRL_START_BIT  = 1;

  // Table operation and status fields
  localparam int          OP_READ_BIT     = 0;
  localparam int          OP_WRITE_BIT    = 1;
  localparam int          STAT_DONE_BIT   = 0;
  localparam int          STAT_BUSY_BIT   = 1;

  localparam logic [7:0]  UNLOCK_FIRST    = 8'h55;
  localparam logic [7:0]  UNLOCK_SECOND   = 8'haa;

  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  localparam logic [15:0] NOP_WORD        = 16'h0000;
  localparam logic [7:0]  LATCH_RESET     = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RESET  = 22'h000000;

  // Programming time and its cycle count, rounded up
  localparam int          PROG_TIME_NS    = 2000;
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          PROG_CYCLES_DEF =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SP_EEPROM, SP_PROG, SP_CONFIG} space_t;
  typedef enum {ST_IDLE, ST_TIMING, ST_COMMIT} op_state_t;

endpackage

// *** core/flash_store.sv ***
// Program flash, data EEPROM and configuration byte arrays
`timescale 1ns/1ps
`default_nettype none
module flash_store
  import flash_table_pkg::*;
#(
  parameter int PROG_BYTES = 8192,
  parameter int EE_BYTES   = 256,
  parameter int CFG_BYTES  = 16
) (
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire space_t                   rd_space_i,
  input  wire logic [PTR_W-1:0]         rd_addr_i,
  output logic      [7:0]               rd_byte_o,
  input  wire logic                     fetch_en_i,
  input  wire logic [PTR_W-2:0]         fetch_addr_i,
  output logic      [15:0]              fetch_word_o,
  input  wire logic                     commit_i,
  input  wire logic                     erase_i,
  input  wire space_t                   wr_space_i,
  input  wire logic [PTR_W-1:0]         wr_addr_i,
  input  wire logic [8*BLOCK_BYTES-1:0] blk_data_i,
  input  wire logic [7:0]               byte_data_i
);
  localparam int PA_W = $clog2(PROG_BYTES);
  localparam int EA_W = $clog2(EE_BYTES);
  localparam int CA_W = $clog2(CFG_BYTES);
  localparam int NBLK = PROG_BYTES / BLOCK_BYTES;
  localparam int BA_W = PA_W - BLOCK_IDX_W;

  // One column per offset in a block, so each column has one writer
  logic [7:0] prog_mem [BLOCK_BYTES][NBLK];
  logic [7:0] ee_mem   [EE_BYTES];
  logic [7:0] cfg_mem  [CFG_BYTES];

  logic [BLOCK_IDX_W-1:0] rd_col;
  logic [BA_W-1:0]        rd_blk;
  logic [BLOCK_IDX_W-1:0] fetch_lo;
  logic [BLOCK_IDX_W-1:0] fetch_hi;
  logic [BA_W-1:0]        fetch_blk;
  logic [BA_W-1:0]        blk_sel;

  assign rd_col    = rd_addr_i[BLOCK_IDX_W-1:0];
  assign rd_blk    = rd_addr_i[PA_W-1:BLOCK_IDX_W];
  // Words sit on even bytes, so both halves share a block
  assign fetch_lo  = {fetch_addr_i[BLOCK_IDX_W-2:0], 1'b0};
  assign fetch_hi  = {fetch_addr_i[BLOCK_IDX_W-2:0], 1'b1};
  assign fetch_blk = fetch_addr_i[PA_W-2:BLOCK_IDX_W-1];
  // Only a block index reaches the array, so no wider erase exists
  assign blk_sel   = wr_addr_i[PA_W-1:BLOCK_IDX_W]; // RULE3 RULE4

  // One byte per read, any byte address
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_byte_o <= 8'h00;
    end else begin
      case (rd_space_i)
        SP_PROG:   rd_byte_o <= prog_mem[rd_col][rd_blk]; // RULE1 RULE11
        SP_EEPROM: rd_byte_o <= ee_mem[rd_addr_i[EA_W-1:0]];
        SP_CONFIG: rd_byte_o <= cfg_mem[rd_addr_i[CA_W-1:0]];
        default:   rd_byte_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_word_o <= NOP_WORD;
    end else if (fetch_en_i) begin
      fetch_word_o <= {prog_mem[fetch_hi][fetch_blk],
                       prog_mem[fetch_lo][fetch_blk]};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BLOCK_BYTES; gi++) begin : g_block
      always_ff @(posedge clock_i) begin
        if (commit_i && wr_space_i == SP_PROG) begin
          prog_mem[gi][blk_sel] <= erase_i ? ERASED_BYTE
            : blk_data_i[8*gi +: 8]; // RULE2 RULE3
        end
      end
    end
  endgenerate

  // EEPROM and configuration cells change one byte at a time
  always_ff @(posedge clock_i) begin
    if (commit_i && wr_space_i == SP_EEPROM) begin
      ee_mem[wr_addr_i[EA_W-1:0]] <= erase_i ? ERASED_BYTE : byte_data_i;
    end
    if (commit_i && wr_space_i == SP_CONFIG) begin
      cfg_mem[wr_addr_i[CA_W-1:0]] <= erase_i ? ERASED_BYTE : byte_data_i;
    end
  end

endmodule // flash_store
`default_nettype wire

// *** core/flash_table_access.sv ***
// Table read/write controller with self-timed flash programming
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module flash_table_access
  import flash_table_pkg::*;
#(
  parameter int PROG_BYTES  = 8192,
  parameter int EE_BYTES    = 256,
  parameter int CFG_BYTES   = 16,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic [PTR_W-2:0]   fetch_addr_i,
  output logic      [15:0]        fetch_word_o,
  output logic                    fetch_stall_o,
  output logic                    memory_done_irq_flag_o
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

  // Software-visible state
  logic             space_select_bit;
  logic             configuration_select_bit;
  logic             erase_select_bit;
  logic             programming_permit_bit;
  logic             start_bit;
  logic             aborted_program_flag;
  logic             memory_done_irq_flag;
  logic [7:0]       table_byte_latch;
  logic [PTR_W-1:0] table_pointer;
  logic [7:0]       holding [BLOCK_BYTES];

  // Internal state
  op_state_t        op_state;
  logic [CNT_W-1:0] prog_count;
  logic [1:0]       unlock_stage;
  logic             rd_pending;
  logic             commit;
  space_t           op_space;
  logic             op_erase;
  logic [PTR_W-1:0] op_addr;
  logic             busy;

  // Bus decode
  logic             setup;
  logic             wr_access;
  logic             mapped;
  logic [7:0]       wbyte;
  logic             ctrl_wr;
  logic             unlock_wr;
  logic             latch_wr;
  logic             ptr_wr;
  logic             op_wr;
  logic             stat_wr;
  logic             start_req;
  logic             start_ok;
  logic             table_read_op;
  logic             table_write_op;
  space_t           cur_space;

  // Array connections
  logic [7:0]               rd_byte;
  logic [15:0]              raw_word;
  logic [8*BLOCK_BYTES-1:0] blk_data;
  logic                     raw_illegal;
  logic                     fetch_en;
  logic [BLOCK_IDX_W-1:0]   hold_idx;

  assign busy      = (op_state != ST_IDLE);
  assign setup     = psel_i && !penable_i;
  assign wr_access = psel_i && penable_i && pwrite_i;
  assign wbyte     = pwdata_i[7:0];
  assign mapped    = (paddr_i == REG_CTRL) || (paddr_i == REG_UNLOCK)
                  || (paddr_i == REG_LATCH) || (paddr_i == REG_POINTER)
                  || (paddr_i == REG_TABLE_OP) || (paddr_i == REG_STATUS);
  assign ctrl_wr   = wr_access && paddr_i == REG_CTRL;
  assign unlock_wr = wr_access && paddr_i == REG_UNLOCK;
  assign latch_wr  = wr_access && paddr_i == REG_LATCH;
  assign ptr_wr    = wr_access && paddr_i == REG_POINTER;
  assign op_wr     = wr_access && paddr_i == REG_TABLE_OP;
  assign stat_wr   = wr_access && paddr_i == REG_STATUS;

  // Writing zero to the start bit is simply not a request
  assign start_req = ctrl_wr && wbyte[CTRL_START_BIT] && !busy; // RULE18
  // Permit must already stand and the unlock pair must be the
  // write just before this one
  assign start_ok  = start_req && programming_permit_bit
                  && unlock_stage == 2'd2; // RULE16 RULE20

  // Table operations are refused while the array is being programmed
  assign table_read_op  = op_wr && wbyte[OP_READ_BIT] && !busy;
  assign table_write_op = op_wr && wbyte[OP_WRITE_BIT] && !busy;

  // Configuration select wins over space select
  always_comb begin
    if (configuration_select_bit) begin
      cur_space = SP_CONFIG; // RULE14
    end else if (space_select_bit) begin
      cur_space = SP_PROG; // RULE13
    end else begin
      cur_space = SP_EEPROM; // RULE13
    end
  end

  // APB: zero wait states; read data is captured in the setup cycle
  assign pready_o = psel_i && penable_i;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= !mapped;
      prdata_o  <= 32'h0000_0000;
      case (paddr_i)
        REG_CTRL: begin
          prdata_o[CTRL_SPACE_BIT]  <= space_select_bit;
          prdata_o[CTRL_CFG_BIT]    <= configuration_select_bit;
          prdata_o[CTRL_ERASE_BIT]  <= erase_select_bit;
          prdata_o[CTRL_ERR_BIT]    <= aborted_program_flag;
          prdata_o[CTRL_PERMIT_BIT] <= programming_permit_bit;
          prdata_o[CTRL_START_BIT]  <= start_bit;
        end
        REG_UNLOCK:  prdata_o <= 32'h0000_0000; // RULE12
        REG_LATCH:   prdata_o[7:0] <= table_byte_latch;
        REG_POINTER: prdata_o[PTR_W-1:0] <= table_pointer;
        REG_STATUS: begin
          prdata_o[STAT_DONE_BIT] <= memory_done_irq_flag;
          prdata_o[STAT_BUSY_BIT] <= busy;
        end
        REG_TABLE_OP: prdata_o <= 32'h0000_0000;
        default:     prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits; permit is cleared by reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      space_select_bit         <= 1'b0;
      configuration_select_bit <= 1'b0;
      erase_select_bit         <= 1'b0;
      programming_permit_bit   <= 1'b0; // RULE16
    end else if (ctrl_wr) begin
      space_select_bit         <= wbyte[CTRL_SPACE_BIT];
      configuration_select_bit <= wbyte[CTRL_CFG_BIT];
      erase_select_bit         <= wbyte[CTRL_ERASE_BIT];
      programming_permit_bit   <= wbyte[CTRL_PERMIT_BIT];
    end
  end

  // Unlock port keeps only sequence progress, never the data
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      unlock_stage <= 2'd0;
    end else if (wr_access) begin
      if (unlock_wr && wbyte == UNLOCK_FIRST) begin
        unlock_stage <= 2'd1; // RULE12
      end else if (unlock_wr && wbyte == UNLOCK_SECOND
                   && unlock_stage == 2'd1) begin
        unlock_stage <= 2'd2; // RULE20
      end else begin
        unlock_stage <= 2'd0;
      end
    end
  end

  // Self-timed sequencer; software only starts it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      op_state   <= ST_IDLE;
      prog_count <= '0;
      op_space   <= SP_EEPROM;
      op_erase   <= 1'b0;
      op_addr    <= PTR_RESET;
    end else begin
      case (op_state)
        ST_IDLE: begin
          if (start_ok) begin
            op_state   <= ST_TIMING;
            prog_count <= '0;
            op_space   <= cur_space;
            op_erase   <= erase_select_bit; // RULE15
            op_addr    <= table_pointer;
          end
        end
        ST_TIMING: begin
          if (prog_count == CNT_LAST) begin
            op_state <= ST_COMMIT; // RULE6
          end else begin
            prog_count <= prog_count + 1'b1; // RULE6
          end
        end
        // Array, flags and holding bytes all update in this one cycle
        ST_COMMIT: op_state <= ST_IDLE;
        default:   op_state <= ST_IDLE;
      endcase
    end
  end

  assign commit = (op_state == ST_COMMIT);

  // Start bit mirrors a running operation; hardware clears it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      start_bit <= 1'b0;
    end else if (start_ok) begin
      start_bit <= 1'b1; // RULE18
    end else if (commit) begin
      start_bit <= 1'b0; // RULE18
    end
  end

  // Error flag also marks a refused start attempt
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      aborted_program_flag <= 1'b0;
    end else if (start_req) begin
      aborted_program_flag <= 1'b1; // RULE17
    end else if (commit) begin
      aborted_program_flag <= 1'b0; // RULE17
    end
  end

  // Done flag: a completion in the clearing cycle still wins
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      memory_done_irq_flag <= 1'b0;
    end else if (commit) begin
      memory_done_irq_flag <= 1'b1; // RULE19
    end else if (stat_wr && wbyte[STAT_DONE_BIT]) begin
      memory_done_irq_flag <= 1'b0; // RULE19
    end
  end

  assign memory_done_irq_flag_o = memory_done_irq_flag;

  // Latch: the array read lands one cycle after the request
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= table_read_op;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      table_byte_latch <= LATCH_RESET;
    end else if (rd_pending) begin
      table_byte_latch <= rd_byte; // RULE8 RULE9
    end else if (latch_wr) begin
      table_byte_latch <= wbyte; // RULE8
    end
  end

  // Pointer is frozen during programming so the target stays put
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      table_pointer <= PTR_RESET;
    end else if (ptr_wr && !busy) begin
      table_pointer <= pwdata_i[PTR_W-1:0];
    end
  end

  // Low pointer bits pick the byte; the upper bits pick the block
  assign hold_idx = table_pointer[BLOCK_IDX_W-1:0]; // RULE21

  // Holding registers; a commit returns them to the erased value
  genvar gi;
  generate
    for (gi = 0; gi < BLOCK_BYTES; gi++) begin : g_hold
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          holding[gi] <= ERASED_BYTE;
        end else if (commit) begin
          holding[gi] <= ERASED_BYTE;
        end else if (table_write_op
                     && hold_idx == BLOCK_IDX_W'(gi)) begin
          holding[gi] <= table_byte_latch; // RULE10 RULE21 RULE11
        end
      end
      assign blk_data[8*gi +: 8] = holding[gi]; // RULE2
    end
  endgenerate

  // Fetch: held off the array while it programs
  assign fetch_stall_o = busy; // RULE5
  // Array port freezes with the output so both resume together
  assign fetch_en = !busy; // RULE5

  function automatic logic word_is_illegal(input logic [15:0] w);
    word_is_illegal = (w[15:8] == 8'h00) && (w[7:0] >= 8'h20)
                   && (w[7:0] != 8'hff);
  endfunction

  // Decoded from the registered array word
  assign raw_illegal = word_is_illegal(raw_word); // RULE7

  // Substitution costs a cycle of fetch latency but keeps decode simple
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_word_o <= NOP_WORD;
    end else if (fetch_en) begin
      fetch_word_o <= raw_illegal ? NOP_WORD
                    : raw_word; // RULE7
    end
  end

  flash_store #(
    .PROG_BYTES (PROG_BYTES),
    .EE_BYTES   (EE_BYTES),
    .CFG_BYTES  (CFG_BYTES)
  ) u_store (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .rd_space_i   (cur_space),
    .rd_addr_i    (table_pointer),
    .rd_byte_o    (rd_byte),
    .fetch_en_i   (fetch_en),
    .fetch_addr_i (fetch_addr_i),
    .fetch_word_o (raw_word),
    .commit_i     (commit),
    .erase_i      (op_erase),
    .wr_space_i   (op_space),
    .wr_addr_i    (op_addr),
    .blk_data_i   (blk_data),
    .byte_data_i  (table_byte_latch)
  );

endmodule // flash_table_access
`default_nettype wire

// *** tb/flash_table_access_sva.sv ***
// Port checks for the table access block
`timescale 1ns/1ps
`default_nettype none
module flash_table_access_sva
  import flash_table_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic               clock_i,
  input wire logic               rst_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pwrite_i,
  input wire logic [PADDR_W-1:0] paddr_i,
  input wire logic [31:0]        pwdata_i,
  input wire logic [31:0]        prdata_o,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  input wire logic [PTR_W-2:0]   fetch_addr_i,
  input wire logic [15:0]        fetch_word_o,
  input wire logic               fetch_stall_o,
  input wire logic               memory_done_irq_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic        acc;
  logic        start_wr;
  logic        done_clr;
  logic [15:0] run_len;

  assign acc      = psel_i && penable_i;
  assign start_wr = acc && pwrite_i && paddr_i == REG_CTRL
                    && pwdata_i[CTRL_START_BIT];
  assign done_clr = acc && pwrite_i && paddr_i == REG_STATUS
                    && pwdata_i[STAT_DONE_BIT];

  // Stall length kept in a counter, the timer count being a parameter
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      run_len <= 16'h0000;
    end else if (fetch_stall_o) begin
      run_len <= run_len + 16'h0001;
    end else begin
      run_len <= 16'h0000;
    end
  end

  sequence run_end_s;
    $fell(fetch_stall_o);
  endsequence

  sequence unlock_rd_s;
    acc && !pwrite_i && paddr_i == REG_UNLOCK;
  endsequence

  unlock_zero_a: assert property (
    unlock_rd_s |-> prdata_o == 32'h0)
    else $error("unlock port read not zero");
  stall_cap_a: assert property (
    run_len <= PROG_CYCLES + 2)
    else $error("fetch stall too long");
  stall_len_a: assert property (
    run_end_s |-> run_len >= PROG_CYCLES + 1 && run_len <= PROG_CYCLES + 2)
    else $error("programming time wrong");
  done_hold_a: assert property (
    memory_done_irq_flag_o && !done_clr |=> memory_done_irq_flag_o)
    else $error("done flag dropped");
  done_clear_a: assert property (
    done_clr && !fetch_stall_o |=> !memory_done_irq_flag_o)
    else $error("done flag not cleared");
  done_cause_a: assert property (
    $rose(memory_done_irq_flag_o) |-> $past(fetch_stall_o))
    else $error("done flag without operation");
  fetch_hold_a: assert property (
    fetch_stall_o && $past(fetch_stall_o) |-> $stable(fetch_word_o))
    else $error("fetch moved while stalled");
  start_cause_a: assert property (
    $rose(fetch_stall_o) |-> $past(start_wr))
    else $error("operation without start write");
endmodule // flash_table_access_sva

bind flash_table_access flash_table_access_sva #(
  .PROG_CYCLES(PROG_CYCLES)
) u_sva (
  .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .fetch_addr_i, .fetch_word_o,
  .fetch_stall_o, .memory_done_irq_flag_o
);
`default_nettype wire

// *** tb/core_model.sv ***
// Processor core model: register bus master and instruction fetch
`timescale 1ns/1ps
`default_nettype none
module core_model
  import flash_table_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic [31:0]        prdata_i,
  input  wire logic               pready_i,
  input  wire logic               pslverr_i,
  input  wire logic [15:0]        fetch_word_i,
  output var  logic               psel_o,
  output var  logic               penable_o,
  output var  logic               pwrite_o,
  output var  logic [PADDR_W-1:0] paddr_o,
  output var  logic [31:0]        pwdata_o,
  output var  logic [PTR_W-2:0]   fetch_addr_o
);
  logic err;

  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
    fetch_addr_o = '0;
  end

  // Request held until pready; software writes start as zero as well as one
  task automatic xfer(input logic w, input logic [PADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Stale data inverted so nothing leans on a released value
    pwdata_o <= ~d;
  endtask

  // Array and substitution both register, so the word settles two edges
  // after the address; it is taken at the third
  task automatic fetch(input logic [PTR_W-2:0] a, output logic [15:0] w);
    @(posedge clock_i);
    fetch_addr_o <= a;
    repeat (3) @(posedge clock_i);
    w = fetch_word_i;
  endtask
endmodule // core_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the flash table access block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_table_pkg::*;
  logic               clk;
  logic               rst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [PTR_W-2:0]   faddr;
  logic [15:0]        fword;
  logic               stall;
  logic               done;
  logic [31:0]        q;
  logic [15:0]        fw;
  int                 mismatches = 0;
  int                 checked = 0;
  int                 cycles = 0;

  flash_table_access #(.PROG_CYCLES(12)) dut (
    .clock_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .fetch_addr_i(faddr), .fetch_word_o(fword), .fetch_stall_o(stall),
    .memory_done_irq_flag_o(done));
  core_model core (
    .clock_i(clk), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .fetch_word_i(fword), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .fetch_addr_o(faddr));

  always #12.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    core.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic tw(input logic [31:0] p, input logic [7:0] b);
    wr(REG_POINTER, p);
    wr(REG_LATCH, {24'h0, b});
    wr(REG_TABLE_OP, 32'h2);
  endtask
  task automatic tr(input logic [31:0] p, input logic [7:0] b);
    wr(REG_POINTER, p);
    wr(REG_TABLE_OP, 32'h1);
    rd(REG_LATCH);
    check(q, {24'h0, b});
  endtask
  function automatic logic [7:0] pat(input int i);
    return (i == 0) ? 8'h20 : (i == 1) ? 8'h00 : 8'(i * 3 + 33);
  endfunction

  task automatic fire(input logic [7:0] c);
    wr(REG_CTRL, {24'h0, c});
    wr(REG_UNLOCK, {24'h0, UNLOCK_FIRST});
    wr(REG_UNLOCK, {24'h0, UNLOCK_SECOND});
    wr(REG_CTRL, {24'h0, c | 8'h02});
    rd(REG_CTRL);
    check(q, {24'h0, c | 8'h0a});
    check(stall, 1'b1);
    wr(REG_CTRL, {24'h0, c});
    rd(REG_CTRL);
    check(q[CTRL_START_BIT], 1'b1);
    rd(REG_STATUS);
    check(q[STAT_BUSY_BIT], 1'b1);
    for (int n = 0; n < 40 && q[STAT_BUSY_BIT] !== 1'b0; n++) begin
      rd(REG_STATUS);
    end
    check(q[STAT_BUSY_BIT], 1'b0);
    check(done, 1'b1);
    rd(REG_CTRL);
    check(q, {24'h0, c});
    wr(REG_STATUS, 32'h1);
    @(negedge clk);
    check(done, 1'b0);
  endtask

  task automatic reset_values();
    logic [7:0] regs [5];
    regs = '{REG_CTRL, REG_UNLOCK, REG_LATCH, REG_POINTER, REG_STATUS};
    wr(REG_UNLOCK, 32'h5a);
    foreach (regs[i]) begin
      rd(regs[i]);
      check(q, 32'h0);
    end
    rd(8'h18);
    check(core.err, 1'b1);
  endtask

  task automatic refused_start();
    wr(REG_CTRL, 32'h84);
    wr(REG_CTRL, 32'h86);
    rd(REG_CTRL);
    check(q, 32'h8c);
    wr(REG_CTRL, 32'h80);
    wr(REG_UNLOCK, {24'h0, UNLOCK_FIRST});
    wr(REG_UNLOCK, {24'h0, UNLOCK_SECOND});
    wr(REG_CTRL, 32'h82);
    rd(REG_CTRL);
    check(q, 32'h88);
    rd(REG_STATUS);
    check(q, 32'h0);
  endtask

  task automatic program_block();
    for (int i = 0; i < BLOCK_BYTES; i++) begin
      tw(32'h40 + i, pat(i));
    end
    fire(8'h84);
    for (int i = 0; i < BLOCK_BYTES; i++) begin
      tr(32'h40 + i, pat(i));
    end
    tw(32'h45, 8'hee);
    tr(32'h45, pat(5));
    core.fetch(21'h20, fw);
    check(fw, 16'h0000);
    core.fetch(21'h21, fw);
    check(fw, {pat(3), pat(2)});
  endtask

  task automatic erase_block();
    wr(REG_POINTER, 32'h45);
    fire(8'h94);
    for (int i = 0; i < BLOCK_BYTES; i += 9) begin
      tr(32'h40 + i, ERASED_BYTE);
    end
    tr(32'h45, ERASED_BYTE);
  endtask

  task automatic space_select();
    tw(32'h43, 8'h5a);
    fire(8'hc4);
    tw(32'h10, 8'h3c);
    fire(8'h04);
    wr(REG_CTRL, 32'h80);
    tr(32'h43, ERASED_BYTE);
    wr(REG_CTRL, 32'hc0);
    tr(32'h43, 8'h5a);
    wr(REG_CTRL, 32'h00);
    tr(32'h10, 8'h3c);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    refused_start();
    program_block();
    erase_block();
    space_select();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
